// >>> hdl/qadc_dev.sv
// converter end: sampling, latency pipe, output format, ddr pairs, registers
// Contract
// - all channels sampled together on falling edge
// - output code appears ten cycles after sampling
// - output words are twos complement
// - ddr pairs, receiver captures on both edges
// - after reset: bits 13..3, zero, one, overrange
// - mandatory bit set: bits 13..1 plus overrange
// - mandatory plus lsb bit gives full 14 bits
// - host writes mandatory bit 7 after reset
// - snr register bit 5 boosts channel c
// - host writes zero to power-down bits 7..4
// - power-down bits 3,2 sleep channels d,c
// - power-down bits 1,0 sleep channels b,a
// - lsb resolution bit 4, resets to zero
// - fast overrange flag seven cycles after overload
// - normal overrange aligned with its sample data
// - each pair muxes two channels, one per edge
module qadc_dev
	import qadc_pkg::*;
(
	qadc_link_if.dev lnk, // link to capture end
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic [NCH-1:0][ADC_W-1:0] ain, // converted codes a..d
	input wire logic [NCH-1:0] ovl, // input overload per channel
	output logic snr_boost_chan_c, // channel c high-snr setting
	output logic sleep_channel_a, // channel a powered down
	output logic sleep_channel_b, // channel b powered down
	output logic sleep_channel_c, // channel c powered down
	output logic sleep_channel_d // channel d powered down
);
	localparam int LAST = DATA_LATENCY - 2;
	localparam int FTAP = EARLY_OVERRANGE_MODE_LATENCY - 2;

	wire clk = lnk.lclk;

	// build one output word; power-down forces zero
	function automatic logic [ADC_W-1:0] fmt_word(
		input logic [ADC_W-1:0] s,
		input logic ov,
		input logic mand,
		input logic full,
		input logic sleep
	);
		logic [ADC_W-1:0] w;
		if (sleep)
			w = '0;
		else if (!mand)
			w = {s[ADC_W-1:3], 1'b0, 1'b1, ov};
		else if (!full)
			w = {s[ADC_W-1:1], ov};
		else
			w = s;
		return w;
	endfunction

	logic ce_s1_reg, ce_s2_reg;
	logic req_s1_reg, req_s2_reg;

	always_ff @(posedge clk or negedge presetn) begin
		if (!presetn) begin
			ce_s1_reg <= 1'b0;
			ce_s2_reg <= 1'b0;
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
		end else begin
			ce_s1_reg <= ce;
			ce_s2_reg <= ce_s1_reg;
			req_s1_reg <= lnk.cfg_req;
			req_s2_reg <= req_s1_reg;
		end
	end

	// sampling flops, read only by the first pipe stage
	logic [NCH-1:0][ADC_W-1:0] smp_reg, smp_next;
	logic [NCH-1:0] ovs_reg, ovs_next;

	always_comb begin
		smp_next = smp_reg;
		ovs_next = ovs_reg;
		if (ce_s2_reg) begin
			smp_next = ain;
			ovs_next = ovl;
		end
	end

	always_ff @(negedge clk or negedge presetn) begin
		if (!presetn) begin
			smp_reg <= '0;
			ovs_reg <= '0;
		end else begin
			smp_reg <= smp_next;
			ovs_reg <= ovs_next;
		end
	end

	// latency pipe; overload flags travel beside their data
	logic [LAST:0][NCH-1:0][ADC_W-1:0] dpipe_reg, dpipe_next;
	logic [LAST:0][NCH-1:0] opipe_reg, opipe_next;

	always_comb begin
		dpipe_next = dpipe_reg;
		opipe_next = opipe_reg;
		if (ce_s2_reg) begin
			dpipe_next[0] = smp_reg;
			opipe_next[0] = ovs_reg;
			for (int k = 1; k <= LAST; k++) begin
				dpipe_next[k] = dpipe_reg[k-1];
				opipe_next[k] = opipe_reg[k-1];
			end
			// an overdriven sample goes to the full-scale code of its sign
			for (int c = 0; c < NCH; c++) begin
				if (opipe_reg[0][c])
					dpipe_next[1][c] = dpipe_reg[0][c][ADC_W-1] ?
						FS_NEG : FS_POS;
			end
		end
	end

	always_ff @(posedge clk or negedge presetn) begin
		if (!presetn) begin
			dpipe_reg <= '0;
			opipe_reg <= '0;
		end else begin
			dpipe_reg <= dpipe_next;
			opipe_reg <= opipe_next;
		end
	end

	// device registers
	logic [7:0] snr_reg, snr_next;
	logic [7:0] mand_reg, mand_next;
	logic [7:0] pdn_reg, pdn_next;
	logic [7:0] fmt_reg, fmt_next;
	logic [7:0] rdata_reg, rdata_next;
	logic seen_reg, seen_next;
	logic ack_reg, ack_next;

	// addr and data are held by the host until the ack toggle returns
	always_comb begin
		snr_next = snr_reg;
		mand_next = mand_reg;
		pdn_next = pdn_reg;
		fmt_next = fmt_reg;
		rdata_next = rdata_reg;
		seen_next = seen_reg;
		ack_next = ack_reg;
		if (ce_s2_reg && req_s2_reg != seen_reg) begin
			seen_next = req_s2_reg;
			ack_next = ~ack_reg;
			if (lnk.cfg_rd) begin
				case (lnk.cfg_addr)
					REG_SNR_C: rdata_next = snr_reg;
					REG_MAND: rdata_next = mand_reg;
					REG_PDN: rdata_next = pdn_reg;
					REG_OUT_FMT: rdata_next = fmt_reg;
					default: rdata_next = 8'h00;
				endcase
			end else begin
				case (lnk.cfg_addr)
					REG_SNR_C: snr_next = lnk.cfg_wdata;
					REG_MAND: mand_next = lnk.cfg_wdata;
					REG_PDN: pdn_next = lnk.cfg_wdata;
					REG_OUT_FMT: fmt_next = lnk.cfg_wdata;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge presetn) begin
		if (!presetn) begin
			snr_reg <= RST_SNR_C;
			mand_reg <= RST_MAND;
			pdn_reg <= RST_PDN;
			fmt_reg <= RST_OUT_FMT;
			rdata_reg <= 8'h00;
			seen_reg <= 1'b0;
			ack_reg <= 1'b0;
		end else begin
			snr_reg <= snr_next;
			mand_reg <= mand_next;
			pdn_reg <= pdn_next;
			fmt_reg <= fmt_next;
			rdata_reg <= rdata_next;
			seen_reg <= seen_next;
			ack_reg <= ack_next;
		end
	end

	// ddr output: rising half carries channel 2g, falling half 2g+1.
	// top bit of each word is the forwarded clock. two flops per pin
	// xor-ed, so every level change comes from a clock edge.
	logic [NPAIR-1:0][ADC_W:0] p_reg, p_next;
	logic [NPAIR-1:0][ADC_W:0] bh_reg, bh_next;
	logic [NPAIR-1:0][ADC_W:0] n_reg, n_next;
	logic [NCH-1:0] ov_sel;
	logic [NCH-1:0] sleep_v;

	always_comb begin
		sleep_v = pdn_reg[NCH-1:0];
		for (int c = 0; c < NCH; c++)
			ov_sel[c] = fmt_reg[NORM_OVR_BIT] ? opipe_reg[LAST][c]
				: opipe_reg[FTAP][c];
		p_next = p_reg;
		bh_next = bh_reg;
		if (ce_s2_reg) begin
			for (int g = 0; g < NPAIR; g++) begin
				p_next[g] = {1'b1, fmt_word(dpipe_reg[LAST][2*g],
					ov_sel[2*g], mand_reg[MAND_BIT],
					fmt_reg[LSB_FULL_BIT], sleep_v[2*g])} ^ n_reg[g];
				bh_next[g] = {1'b0, fmt_word(dpipe_reg[LAST][2*g+1],
					ov_sel[2*g+1], mand_reg[MAND_BIT],
					fmt_reg[LSB_FULL_BIT], sleep_v[2*g+1])};
			end
		end
	end

	always_ff @(posedge clk or negedge presetn) begin
		if (!presetn) begin
			p_reg <= '0;
			bh_reg <= '0;
		end else begin
			p_reg <= p_next;
			bh_reg <= bh_next;
		end
	end

	always_comb begin
		n_next = n_reg;
		if (ce_s2_reg) begin
			for (int g = 0; g < NPAIR; g++)
				n_next[g] = bh_reg[g] ^ p_reg[g];
		end
	end

	always_ff @(negedge clk or negedge presetn) begin
		if (!presetn)
			n_reg <= '0;
		else
			n_reg <= n_next;
	end

	always_comb begin
		for (int g = 0; g < NPAIR; g++) begin
			lnk.pair_data[g] = p_reg[g][ADC_W-1:0] ^ n_reg[g][ADC_W-1:0];
			lnk.pair_clk[g] = p_reg[g][ADC_W] ^ n_reg[g][ADC_W];
		end
	end

	assign lnk.cfg_rdata = rdata_reg;
	assign lnk.cfg_ack = ack_reg;
	assign snr_boost_chan_c = snr_reg[SNR_C_BIT];
	assign sleep_channel_a = pdn_reg[SLEEP_A_BIT];
	assign sleep_channel_b = pdn_reg[SLEEP_B_BIT];
	assign sleep_channel_c = pdn_reg[SLEEP_C_BIT];
	assign sleep_channel_d = pdn_reg[SLEEP_D_BIT];
endmodule

// >>> hdl/qadc_host.sv
// capture end: apb registers, device configuration, ddr pair capture
module qadc_host
	import qadc_pkg::*;
(
	qadc_link_if.rx lnk, // link to converter end
	input wire logic pclk, // apb clock
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, freezes pclk state when low
	input wire logic [APB_AW-1:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr // apb error
);
	// force reserved bits of known device registers to zero
	function automatic logic [7:0] clean(input logic [7:0] a,
		input logic [7:0] d);
		logic [7:0] r;
		case (a)
			REG_SNR_C: r = d & WMASK_SNR_C;
			REG_MAND: r = d & WMASK_MAND;
			REG_PDN: r = d & WMASK_PDN;
			REG_OUT_FMT: r = d & WMASK_OUT_FMT;
			default: r = d;
		endcase
		return r;
	endfunction

	logic snap_reg, snap_next;

	// per pair: rising edge takes the first channel, falling the second.
	// each edge sees the half-word launched by that same edge, so the
	// pair is closed on the fall and both halves belong to one sample
	for (genvar g = 0; g < NPAIR; g++) begin : g_pair
		logic [ADC_W-1:0] a_reg;
		logic arm_s1, arm_s2;
		logic done_reg, done_next;
		logic [2*ADC_W-1:0] hold_reg, hold_next;

		always_ff @(posedge lnk.pair_clk[g] or negedge presetn) begin
			if (!presetn)
				a_reg <= '0;
			else
				a_reg <= lnk.pair_data[g];
		end

		always_comb begin
			hold_next = hold_reg;
			done_next = done_reg;
			if (arm_s2 != done_reg) begin
				hold_next = {lnk.pair_data[g], a_reg};
				done_next = arm_s2;
			end
		end

		always_ff @(negedge lnk.pair_clk[g] or negedge presetn) begin
			if (!presetn) begin
				arm_s1 <= 1'b0;
				arm_s2 <= 1'b0;
				done_reg <= 1'b0;
				hold_reg <= '0;
			end else begin
				arm_s1 <= snap_reg;
				arm_s2 <= arm_s1;
				done_reg <= done_next;
				hold_reg <= hold_next;
			end
		end
	end

	qadc_hst_t st_reg, st_next;
	logic req_reg, req_next;
	logic rd_reg, rd_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [7:0] crd_reg, crd_next;
	logic ack_s1_reg, ack_s2_reg, ack_seen_reg, ack_seen_next;
	logic [NPAIR-1:0] done_s1_reg, done_s2_reg;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic access, snap_busy;
	logic [7:0] cmd_addr;

	always_comb begin
		st_next = st_reg;
		req_next = req_reg;
		rd_next = rd_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		crd_next = crd_reg;
		ack_seen_next = ack_seen_reg;
		snap_next = snap_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		access = psel & penable & ~pready_reg;
		snap_busy = (done_s2_reg != {NPAIR{snap_reg}});
		cmd_addr = pwdata[CMD_ADDR_LSB +: 8];
		case (st_reg)
			HS_INIT: begin
				// the mandatory bit goes out first, before any software access
				addr_next = REG_MAND;
				wdata_next = clean(REG_MAND, MAND_VALUE);
				rd_next = 1'b0;
				req_next = ~req_reg;
				st_next = HS_WAIT;
			end
			HS_WAIT: begin
				if (ack_s2_reg != ack_seen_reg) begin
					ack_seen_next = ack_s2_reg;
					if (rd_reg)
						crd_next = lnk.cfg_rdata;
					st_next = HS_IDLE;
				end
			end
			HS_IDLE: ;
			default: st_next = HS_INIT;
		endcase
		if (access) begin
			pready_next = 1'b1;
			prdata_next = 32'h0000_0000;
			case (paddr)
				OFS_CMD: begin
					if (!pwrite)
						prdata_next = {15'h0000, rd_reg, addr_reg, wdata_reg};
					else if (st_reg == HS_IDLE) begin
						rd_next = pwdata[CMD_RD_BIT];
						addr_next = cmd_addr;
						wdata_next = clean(cmd_addr, pwdata[7:0]);
						req_next = ~req_reg;
						st_next = HS_WAIT;
					end else
						pslverr_next = 1'b1;
				end
				OFS_STAT: begin
					prdata_next[STAT_CFG_BUSY_BIT] = (st_reg != HS_IDLE);
					prdata_next[STAT_SNAP_BUSY_BIT] = snap_busy;
					prdata_next[STAT_RDATA_LSB +: 8] = crd_reg;
				end
				OFS_SNAP: begin
					if (pwrite && !snap_busy)
						snap_next = ~snap_reg;
					else if (pwrite)
						pslverr_next = 1'b1;
				end
				// hold words only change while a snapshot is pending
				OFS_CAP_AB: prdata_next = {2'b00,
					g_pair[0].hold_reg[2*ADC_W-1:ADC_W],
					2'b00, g_pair[0].hold_reg[ADC_W-1:0]};
				OFS_CAP_CD: prdata_next = {2'b00,
					g_pair[1].hold_reg[2*ADC_W-1:ADC_W],
					2'b00, g_pair[1].hold_reg[ADC_W-1:0]};
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= HS_INIT;
			req_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			crd_reg <= 8'h00;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			done_s1_reg <= '0;
			done_s2_reg <= '0;
			snap_reg <= 1'b0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			st_reg <= st_next;
			req_reg <= req_next;
			rd_reg <= rd_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			crd_reg <= crd_next;
			ack_s1_reg <= lnk.cfg_ack;
			ack_s2_reg <= ack_s1_reg;
			ack_seen_reg <= ack_seen_next;
			done_s1_reg <= {g_pair[1].done_reg, g_pair[0].done_reg};
			done_s2_reg <= done_s1_reg;
			snap_reg <= snap_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	assign lnk.cfg_req = req_reg;
	assign lnk.cfg_rd = rd_reg;
	assign lnk.cfg_addr = addr_reg;
	assign lnk.cfg_wdata = wdata_reg;
	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
endmodule

// >>> hdl/qadc_link_if.sv
// link between the converter end and the capture end
interface qadc_link_if;
	import qadc_pkg::*;
	logic lclk;
	logic [NPAIR-1:0][ADC_W-1:0] pair_data;
	logic [NPAIR-1:0] pair_clk;
	logic cfg_req;
	logic cfg_rd;
	logic [7:0] cfg_addr;
	logic [7:0] cfg_wdata;
	logic [7:0] cfg_rdata;
	logic cfg_ack;

	modport dev (
		input lclk, cfg_req, cfg_rd, cfg_addr, cfg_wdata,
		output pair_data, pair_clk, cfg_rdata, cfg_ack
	);
	modport rx (
		input pair_data, pair_clk, cfg_rdata, cfg_ack,
		output cfg_req, cfg_rd, cfg_addr, cfg_wdata
	);
endinterface

// >>> hdl/qadc_pkg.sv
// shared constants and types for the quad converter output link
package qadc_pkg;
	localparam int ADC_W = 14;
	localparam int NCH = 4;
	localparam int NPAIR = 2;
	localparam int DATA_LATENCY = 10;
	localparam int EARLY_OVERRANGE_MODE_LATENCY = 7;

	localparam logic [7:0] REG_SNR_C = 8'hA0;
	localparam logic [7:0] REG_MAND = 8'hA1;
	localparam logic [7:0] REG_PDN = 8'hFE;
	localparam logic [7:0] REG_OUT_FMT = 8'hB0;

	localparam logic [7:0] RST_SNR_C = 8'h00;
	localparam logic [7:0] RST_MAND = 8'h00;
	localparam logic [7:0] RST_PDN = 8'h00;
	localparam logic [7:0] RST_OUT_FMT = 8'h00;

	localparam int SNR_C_BIT = 5;
	localparam int MAND_BIT = 7;
	localparam int LSB_FULL_BIT = 4;
	localparam int NORM_OVR_BIT = 3;
	localparam int SLEEP_A_BIT = 0;
	localparam int SLEEP_B_BIT = 1;
	localparam int SLEEP_C_BIT = 2;
	localparam int SLEEP_D_BIT = 3;

	localparam logic [7:0] WMASK_SNR_C = 8'h20;
	localparam logic [7:0] WMASK_MAND = 8'h80;
	localparam logic [7:0] WMASK_PDN = 8'h0F;
	localparam logic [7:0] WMASK_OUT_FMT = 8'h18;
	localparam logic [7:0] MAND_VALUE = 8'h80;

	localparam logic [ADC_W-1:0] FS_POS = 14'h1FFF;
	localparam logic [ADC_W-1:0] FS_NEG = 14'h2000;

	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] OFS_CMD = 12'h000;
	localparam logic [APB_AW-1:0] OFS_STAT = 12'h004;
	localparam logic [APB_AW-1:0] OFS_SNAP = 12'h008;
	localparam logic [APB_AW-1:0] OFS_CAP_AB = 12'h00C;
	localparam logic [APB_AW-1:0] OFS_CAP_CD = 12'h010;
	localparam int CMD_RD_BIT = 16;
	localparam int CMD_ADDR_LSB = 8;
	localparam int STAT_CFG_BUSY_BIT = 0;
	localparam int STAT_SNAP_BUSY_BIT = 1;
	localparam int STAT_RDATA_LSB = 8;

	typedef enum logic [1:0] {
		HS_INIT = 2'b00,
		HS_IDLE = 2'b01,
		HS_WAIT = 2'b10
	} qadc_hst_t;
endpackage

// >>> sim/qadc_link_assertions.sv
// checker on the link between converter end and capture end
module qadc_link_assertions
	import qadc_pkg::*;
(
	input logic lclk, // link clock
	input logic presetn, // async reset, active low
	input logic [NPAIR-1:0][ADC_W-1:0] pair_data, // ddr data
	input logic [NPAIR-1:0] pair_clk, // forwarded clocks
	input logic cfg_req, // request toggle
	input logic cfg_rd, // read select
	input logic [7:0] cfg_addr, // register address
	input logic [7:0] cfg_wdata, // write data
	input logic [7:0] cfg_rdata, // read data
	input logic cfg_ack // answer toggle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] lcnt_reg;
	logic seen_req_reg;
	default clocking @(posedge lclk); endclocking
	default disable iff (!presetn);
	// warm-up count keeps output checks clear of the reset flush
	always_ff @(posedge lclk or negedge presetn) begin
		if (!presetn) begin
			lcnt_reg <= 4'h0;
			seen_req_reg <= 1'b0;
		end else begin
			if (lcnt_reg != 4'hF)
				lcnt_reg <= lcnt_reg + 4'h1;
			if ($changed(cfg_req))
				seen_req_reg <= 1'b1;
		end
	end
	a_first_mand: assert property ($changed(cfg_req) && !seen_req_reg |->
		!cfg_rd && cfg_addr == REG_MAND && cfg_wdata == MAND_VALUE)
		else $error("first access is not the mandatory write");
	a_ack_answers: assert property ($changed(cfg_req) |-> ##[1:6]
		$changed(cfg_ack)) else $error("request not answered");
	a_ack_matches: assert property ($changed(cfg_ack) |->
		cfg_ack == cfg_req) else $error("answer without request");
	a_cfg_held: assert property (cfg_req != cfg_ack &&
		$past(cfg_req != cfg_ack) |-> $stable(cfg_addr) &&
		$stable(cfg_wdata) && $stable(cfg_rd))
		else $error("request changed while pending");
	a_rdata_snr: assert property ($changed(cfg_ack) && cfg_rd &&
		cfg_addr == REG_SNR_C |-> (cfg_rdata & ~WMASK_SNR_C) == 8'h00)
		else $error("snr register holds stray bits");
	a_rdata_pdn: assert property ($changed(cfg_ack) && cfg_rd &&
		cfg_addr == REG_PDN |-> (cfg_rdata & ~WMASK_PDN) == 8'h00)
		else $error("power-down register holds stray bits");
	a_clk_low_rise: assert property (lcnt_reg == 4'hF |->
		pair_clk == 2'b00)
		else $error("pair clock not low before rise");
	a_clk_high_fall: assert property (@(negedge lclk)
		disable iff (!presetn) lcnt_reg == 4'hF |-> pair_clk == 2'b11)
		else $error("pair clock not high before fall");
	a_default_fmt: assert property (!seen_req_reg && lcnt_reg == 4'hF |->
		pair_data[0][2:1] == 2'b01 && pair_data[1][2:1] == 2'b01)
		else $error("default format constant bits wrong");
	c_dev_read: cover property ($changed(cfg_ack) && cfg_rd);
	c_dev_write: cover property ($changed(cfg_ack) && !cfg_rd);
	c_warm_default: cover property (!seen_req_reg && lcnt_reg == 4'hF);
endmodule

// >>> sim/quad_adc_output_format_config_bench.sv
// bench joining converter end and capture end over the link
module quad_adc_output_format_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import qadc_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, dce = 1'b1, hce = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [NCH-1:0][ADC_W-1:0] ain = '0;
	logic [NCH-1:0] ovl = '0;
	wire snr_c;
	logic mand = 1'b0, full = 1'b0;
	wire [3:0] slp;
	logic [3:0] pdn = 4'h0;
	logic [33:0] exp_q[$];
	logic [7:0] fmts[4] = '{8'h18, 8'h08, 8'h00, 8'h10};
	int error_cnt = 0, n_checks = 0, seed = 32'hf63caad2;
	qadc_link_if lnk();
	qadc_dev u_qadc_dev(.lnk(lnk), .presetn(presetn), .ce(dce), .ain(ain),
		.ovl(ovl), .snr_boost_chan_c(snr_c), .sleep_channel_a(slp[0]),
		.sleep_channel_b(slp[1]), .sleep_channel_c(slp[2]),
		.sleep_channel_d(slp[3]));
	qadc_host u_qadc_host(.lnk(lnk), .pclk(pclk), .presetn(presetn),
		.ce(hce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));
	qadc_link_assertions u_qadc_link_assertions(.lclk(lnk.lclk),
		.presetn(presetn), .pair_data(lnk.pair_data), .pair_clk(lnk.pair_clk),
		.cfg_req(lnk.cfg_req), .cfg_rd(lnk.cfg_rd), .cfg_addr(lnk.cfg_addr),
		.cfg_wdata(lnk.cfg_wdata), .cfg_rdata(lnk.cfg_rdata),
		.cfg_ack(lnk.cfg_ack));
	initial forever #20 pclk = ~pclk;
	// link clock free-runs: it is the sampling clock, phase unrelated
	initial begin
		lnk.lclk = 1'b0;
		#7;
		forever #80 lnk.lclk = ~lnk.lclk;
	end
	function automatic logic [13:0] word(input int c);
		logic [13:0] s;
		s = ovl[c] ? (ain[c][13] ? FS_NEG : FS_POS) : ain[c];
		if (pdn[c])
			return 14'h0000;
		if (!mand)
			return {s[13:3], 2'b01, ovl[c]};
		if (!full)
			return {s[13:1], ovl[c]};
		return s;
	endfunction
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, input logic sk, input logic e,
		input logic [31:0] x);
		exp_q.push_back({sk, e, w ? 32'h0 : x});
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	always @(posedge pclk) begin
		logic [33:0] e;
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			if (!e[33])
				chk({1'b0, pslverr, pwrite ? 32'h0 : prdata}, e);
		end
	end
	task automatic poll(input int b);
		repeat (80) begin
			apb(OFS_STAT, 1'b0, 32'h0, 1'b1, 1'b0, 32'h0);
			if (r[b] === 1'b0)
				break;
		end
		chk(r[b], 1'b0);
	endtask
	task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
		apb(OFS_CMD, 1'b1, {16'h0000, a, d}, 1'b0, 1'b0, 32'h0);
		poll(STAT_CFG_BUSY_BIT);
	endtask
	task automatic dev_rd(input logic [7:0] a, input logic [7:0] x);
		apb(OFS_CMD, 1'b1, {15'h0000, 1'b1, a, 8'h00}, 1'b0, 1'b0, 32'h0);
		poll(STAT_CFG_BUSY_BIT);
		apb(OFS_STAT, 1'b0, 32'h0, 1'b0, 1'b0, {16'h0000, x, 8'h00});
	endtask
	task automatic set_ain(input logic ov);
		@(posedge lnk.lclk);
		for (int i = 0; i < NCH; i++)
			ain[i] <= 14'($random(seed));
		ovl <= ov ? 4'($random(seed)) : 4'h0;
	endtask
	task automatic cap_chk();
		repeat (14) @(posedge lnk.lclk);
		apb(OFS_SNAP, 1'b1, 32'h0, 1'b0, 1'b0, 32'h0);
		poll(STAT_SNAP_BUSY_BIT);
		apb(OFS_CAP_AB, 1'b0, 32'h0, 1'b0, 1'b0,
			{2'b00, word(1), 2'b00, word(0)});
		apb(OFS_CAP_CD, 1'b0, 32'h0, 1'b0, 1'b0,
			{2'b00, word(3), 2'b00, word(2)});
	endtask
	// one overloaded sample on channel a: the flag leads in fast mode,
	// and rides with the saturated data in normal mode
	task automatic ovr_chk(input logic [7:0] f, input int lat);
		logic [13:0] s;
		dev_wr(REG_OUT_FMT, f);
		s = (lat == DATA_LATENCY) ? (ain[0][13] ? FS_NEG : FS_POS) : ain[0];
		@(posedge lnk.lclk);
		ovl <= 4'h0;
		repeat (12) @(posedge lnk.lclk);
		ovl <= 4'h1;
		@(posedge lnk.lclk);
		ovl <= 4'h0;
		repeat (lat - 2) @(posedge lnk.lclk);
		#1;
		chk(lnk.pair_data[0][0], 1'b0);
		@(posedge lnk.lclk);
		#1;
		chk(lnk.pair_data[0], {s[13:1], 1'b1});
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// host frozen, so the device keeps its reset-time format
		set_ain(1'b0);
		repeat (14) @(posedge lnk.lclk);
		@(posedge lnk.lclk);
		#1;
		chk(lnk.pair_data, {word(2), word(0)});
		@(negedge lnk.lclk);
		#1;
		chk(lnk.pair_data, {word(3), word(1)});
		@(posedge lnk.lclk);
		ain[0] <= ~ain[0];
		@(negedge lnk.lclk);
		repeat (9) @(posedge lnk.lclk);
		#1;
		chk(lnk.pair_data[0] !== word(0), 1'b1);
		@(posedge lnk.lclk);
		#1;
		chk(lnk.pair_data[0], word(0));
		$display("test default format done");
		@(posedge pclk);
		hce <= 1'b1;
		poll(STAT_CFG_BUSY_BIT);
		mand = 1'b1;
		dev_rd(REG_MAND, MAND_VALUE);
		dev_rd(REG_SNR_C, RST_SNR_C);
		dev_rd(REG_PDN, RST_PDN);
		dev_rd(REG_OUT_FMT, RST_OUT_FMT);
		cap_chk();
		$display("test mandatory format done");
		apb(12'h0FC, 1'b0, 32'h0, 1'b0, 1'b1, 32'h0);
		apb(OFS_CMD, 1'b1, {16'h0000, REG_SNR_C, 8'hFF}, 1'b0, 1'b0, 32'h0);
		apb(OFS_CMD, 1'b1, {16'h0000, REG_PDN, 8'h0F}, 1'b0, 1'b1, 32'h0);
		poll(STAT_CFG_BUSY_BIT);
		apb(OFS_CMD, 1'b0, 32'h0, 1'b0, 1'b0,
			{16'h0000, REG_SNR_C, WMASK_SNR_C});
		chk(snr_c, 1'b1);
		dev_rd(REG_SNR_C, WMASK_SNR_C);
		$display("test refusal and snr done");
		for (int i = 0; i < NCH; i++) begin
			pdn = 4'(1 << i);
			dev_wr(REG_PDN, {4'hF, pdn});
			dev_rd(REG_PDN, {4'h0, pdn});
			chk(slp, pdn);
			cap_chk();
		end
		pdn = 4'h0;
		dev_wr(REG_PDN, 8'h00);
		$display("test power-down done");
		for (int i = 0; i < 4; i++) begin
			full = fmts[i][LSB_FULL_BIT];
			dev_wr(REG_OUT_FMT, fmts[i]);
			set_ain(1'b1);
			cap_chk();
		end
		$display("test resolution and overrange done");
		ovr_chk(8'h00, EARLY_OVERRANGE_MODE_LATENCY);
		ovr_chk(8'h08, DATA_LATENCY);
		$display("test overrange timing done");
		test_done();
	end
	initial begin
		#1000000;
		error_cnt++;
		test_done();
	end
endmodule
